// *** rspi_port.sv ***
// Purpose: Serial slave port to the radio register file
// Assumes: Serial clock far slower than clk_in; mode 0 framing
// Notes: Writes queue through a FIFO to the register side
`timescale 1ns/10ps
`include "rspi_consts.svh"
// Function
// R01: 3-wire: shared data pin, master clock
// R02: Master tristates data unless sending
// R03: Master swaps pin direction itself
// R04: Talk only while select low
// R05: Shared IRQ hidden while select low
// R06: Master tristates data while select high
// R07: 4-wire: in on MOSI, out MISO
// R08: Command byte then data bytes
// R09: Bit 7 direction, one is write
// R10: Bit 6 increment, bits 5:0 address
// R11: Increment address after each byte
// R12: No increment: same address, file steps
// R13: Port timed only by serial clock; code samples the pins and runs on clk_in
// R14: MISO and IRQ pins usable as GPIO
// R15: Master picks wiring via serial_link_config
// R16: MSB first, sample rise, change fall
// R17: Select high aborts and resets port
module rspi_port
  import rspi_pkg::*;
#(
  parameter int FIFO_DEPTH = `RSPI_FIFO_DEPTH
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic sck_in,
  input wire logic ss_n_in,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe_out,
  output logic miso_out,
  output logic miso_oe_out,
  input wire logic three_wire_in,
  input wire logic irq_on_mosi_in,
  input wire logic irq_in,
  output logic irq_out,
  output logic irq_oe_out,
  input wire logic miso_gpio_en_in,
  input wire logic miso_gpio_out_in,
  input wire logic irq_gpio_en_in,
  input wire logic irq_gpio_out_in,
  input wire logic [`RSPI_ADDR_W-1:0] file_mask_in,
  output logic [`RSPI_ADDR_W-1:0] rd_addr_out,
  input wire logic [`RSPI_BYTE_W-1:0] rd_data_in,
  output logic rd_strobe_out,
  output logic wr_valid_out,
  output logic [`RSPI_ADDR_W+`RSPI_BYTE_W-1:0] wr_data_out,
  input wire logic wr_ready_in,
  output logic busy_out
);
  localparam int WW = `RSPI_ADDR_W + `RSPI_BYTE_W;

  ////////////////////////////////////////////////////////////////
  // Pin synchronisers; first stage read only by the second
  logic [1:0] sck_s_q, ss_s_q, mosi_s_q;
  logic sck_d1_q;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sck_s_q <= 2'h0;
      ss_s_q <= 2'h3;
      mosi_s_q <= 2'h0;
      sck_d1_q <= 1'b0;
    end else begin
      sck_s_q <= {sck_s_q[0], sck_in};
      ss_s_q <= {ss_s_q[0], ss_n_in};
      mosi_s_q <= {mosi_s_q[0], mosi_in};
      sck_d1_q <= sck_s_q[1];
    end
  end
  wire sck_sync = sck_s_q[1];
  wire ss_n_sync = ss_s_q[1];
  wire mosi_sync = mosi_s_q[1];
  wire selected = !ss_n_sync; // [R04]
  // Edges only count inside a frame, the clock may stop outside it
  wire sck_rise = selected && sck_sync && !sck_d1_q; // [R13] [R16]
  wire sck_fall = selected && !sck_sync && sck_d1_q; // [R16]

  ////////////////////////////////////////////////////////////////
  // Byte framing
  rspi_state_t st_q, st_d;
  logic [`RSPI_BIT_CNT_W-1:0] bit_q;
  logic [`RSPI_BYTE_W-1:0] sh_in_q, sh_out_q;
  logic [`RSPI_ADDR_W-1:0] addr_q, addr_d;
  logic [`RSPI_ADDR_W-1:0] fidx_q;
  logic inc_q;
  logic load_q;
  logic tx_live_q;

  wire [`RSPI_BYTE_W-1:0] byte_in = {sh_in_q[`RSPI_BYTE_W-2:0], mosi_sync};
  wire byte_done = sck_rise && (bit_q == `RSPI_BIT_LAST); // [R08]
  wire is_write = byte_in[`RSPI_CMD_DIR_BIT]; // [R09]
  wire cmd_inc = byte_in[`RSPI_CMD_INC_BIT]; // [R10]
  wire [`RSPI_ADDR_W-1:0] cmd_addr = byte_in[`RSPI_ADDR_W-1:0]; // [R10]
  // Fixed address; file registers step within the masked low bits
  wire [`RSPI_ADDR_W-1:0] fidx_nx = fidx_q + 1'b1;
  wire [`RSPI_ADDR_W-1:0] eff_addr = inc_q ? addr_q
    : ((addr_q & ~file_mask_in) | (fidx_q & file_mask_in)); // [R12]
  wire data_byte = byte_done && (st_q != RSPI_CMD);

  always_comb begin
    st_d = st_q;
    addr_d = addr_q;
    if (byte_done) begin
      case (st_q)
        RSPI_CMD: begin
          st_d = is_write ? RSPI_WDATA : RSPI_RDATA;
          addr_d = cmd_addr;
        end
        RSPI_WDATA, RSPI_RDATA: begin
          if (inc_q) addr_d = addr_q + 1'b1; // [R11]
        end
        default: st_d = RSPI_CMD;
      endcase
    end
  end

  rspi_fifo_if #(.W(WW)) wf();
  assign wf.valid = data_byte && (st_q == RSPI_WDATA);
  assign wf.data = {eff_addr, byte_in};

  always_ff @(posedge clk_in) begin
    if (rst_in || !selected) begin // [R17]
      st_q <= RSPI_CMD;
      bit_q <= '0;
      sh_in_q <= '0;
      addr_q <= '0;
      fidx_q <= '0;
      inc_q <= 1'b0;
    end else begin
      st_q <= st_d;
      addr_q <= addr_d;
      if (sck_rise) begin
        bit_q <= bit_q + 1'b1;
        sh_in_q <= byte_in;
      end
      if (byte_done && st_q == RSPI_CMD) inc_q <= cmd_inc;
      if (data_byte && !inc_q) fidx_q <= fidx_nx; // [R12]
    end
  end

  ////////////////////////////////////////////////////////////////
  // Read path: fetch after each byte boundary, load on next fall
  assign rd_addr_out = eff_addr;
  wire rd_fetch = byte_done && (st_d == RSPI_RDATA);
  always_ff @(posedge clk_in) begin
    if (rst_in || !selected) begin
      load_q <= 1'b0;
      sh_out_q <= '0;
      rd_strobe_out <= 1'b0;
      tx_live_q <= 1'b0;
    end else begin
      rd_strobe_out <= rd_fetch;
      if (rd_fetch) load_q <= 1'b1;
      if (sck_fall) begin
        load_q <= 1'b0;
        sh_out_q <= load_q ? rd_data_in : {sh_out_q[`RSPI_BYTE_W-2:0], 1'b0}; // [R16]
        // Master may still drive its last command bit until this fall
        if (st_q == RSPI_RDATA) tx_live_q <= 1'b1; // [R01]
      end
    end
  end
  wire tx_bit = sh_out_q[`RSPI_BYTE_W-1];
  wire rd_phase = selected && (st_q == RSPI_RDATA);

  ////////////////////////////////////////////////////////////////
  // Pin muxing
  wire irq_share = irq_on_mosi_in && !selected; // [R05]
  // Turnaround waits for the first fall, so the two ends never fight
  wire drive_shared = three_wire_in && rd_phase && tx_live_q; // [R01]
  assign mosi_out = drive_shared ? tx_bit : irq_in; // [R01]
  assign mosi_oe_out = drive_shared || irq_share; // [R01] [R05]
  assign miso_out = miso_gpio_en_in ? miso_gpio_out_in : tx_bit; // [R07] [R14]
  assign miso_oe_out = miso_gpio_en_in || (!three_wire_in && rd_phase); // [R07] [R14]
  assign irq_out = irq_gpio_en_in ? irq_gpio_out_in : irq_in; // [R14]
  assign irq_oe_out = irq_gpio_en_in || !irq_on_mosi_in; // [R14]
  assign busy_out = selected;

  rspi_fifo #(.WIDTH(WW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .wr(wf),
    .rd_ready_in(wr_ready_in),
    .rd_valid_out(wr_valid_out),
    .rd_data_out(wr_data_out)
  );

  ////////////////////////////////////////////////////////////////
  // Checks
  a_irq_hidden_sel: assert property (@(posedge clk_in) disable iff (rst_in) // [R05]
    (irq_on_mosi_in && selected && !drive_shared) |-> !mosi_oe_out)
    else $error("irq driven on mosi while selected");
  a_abort_on_desel: assert property (@(posedge clk_in) disable iff (rst_in) // [R17]
    $rose(ss_n_sync) |=> (st_q == RSPI_CMD && bit_q == 0))
    else $error("deselect did not abort");
  a_cmd_to_state: assert property (@(posedge clk_in) disable iff (rst_in) // [R09]
    (byte_done && st_q == RSPI_CMD && selected) |=>
      (st_q == ($past(is_write) ? RSPI_WDATA : RSPI_RDATA) || !selected))
    else $error("direction bit misdecoded");
  a_addr_inc: assert property (@(posedge clk_in) disable iff (rst_in) // [R11]
    (data_byte && inc_q && selected) |=> (addr_q == $past(addr_q) + 1'b1 || !selected))
    else $error("address not incremented");
  a_addr_hold: assert property (@(posedge clk_in) disable iff (rst_in) // [R12]
    (data_byte && !inc_q && selected) |=> (addr_q == $past(addr_q) || !selected))
    else $error("address changed without increment");
  a_wr_push: assert property (@(posedge clk_in) disable iff (rst_in) // [R08]
    (byte_done && st_q == RSPI_WDATA && wf.ready) |-> wf.valid ##1 wr_valid_out)
    else $error("write byte not queued");
  a_miso_4wire: assert property (@(posedge clk_in) disable iff (rst_in) // [R07]
    (!three_wire_in && !miso_gpio_en_in && rd_phase) |-> (miso_oe_out && miso_out == tx_bit))
    else $error("miso not driving read data");
  a_mosi_3wire: assert property (@(posedge clk_in) disable iff (rst_in) // [R01]
    (three_wire_in && !rd_phase && !irq_share) |-> !mosi_oe_out)
    else $error("shared pin driven outside read");
  a_turn_wait: assert property (@(posedge clk_in) disable iff (rst_in) // [R01]
    (rd_phase && !tx_live_q) |-> !mosi_oe_out)
    else $error("shared pin driven before turnaround");
  c_write_burst: cover property (@(posedge clk_in) st_q == RSPI_WDATA ##1 data_byte);
  c_read_burst: cover property (@(posedge clk_in) st_q == RSPI_RDATA ##1 rd_strobe_out);
  c_abort_mid: cover property (@(posedge clk_in) (bit_q != 0) ##1 !selected);
  c_shared_read: cover property (@(posedge clk_in) drive_shared ##1 sck_fall);
  c_file_step: cover property (@(posedge clk_in) data_byte && !inc_q && (file_mask_in != '0));
endmodule

// *** rspi_consts.svh ***
// Purpose: Constants for the radio serial register port
// Assumes: Included by bare name
// Notes: Offsets and positions named once here
`ifndef RSPI_CONSTS_SVH
`define RSPI_CONSTS_SVH
`define RSPI_CMD_DIR_BIT 7
`define RSPI_CMD_INC_BIT 6
`define RSPI_ADDR_W 6
`define RSPI_BYTE_W 8
`define RSPI_BIT_CNT_W 3
`define RSPI_BIT_LAST 3'h7
`define RSPI_FIFO_DEPTH 32
`define RSPI_FILE_IDX_W 4
`endif

// *** rspi_pkg.sv ***
// Purpose: Types for the radio serial register port
// Assumes: rspi_consts.svh gives widths
// Notes: Types only
`include "rspi_consts.svh"
package rspi_pkg;
  typedef enum logic [1:0] {RSPI_CMD, RSPI_WDATA, RSPI_RDATA} rspi_state_t;
  typedef logic [`RSPI_BYTE_W-1:0] rspi_byte_t;
  typedef logic [`RSPI_ADDR_W-1:0] rspi_addr_t;
endpackage

// *** rspi_fifo_if.sv ***
// Purpose: Stream carrier between port and FIFO
// Assumes: One clock
// Notes: Valid/ready on both sides
`timescale 1ns/10ps
interface rspi_fifo_if #(parameter int W = 14);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// *** rspi_fifo.sv ***
// Purpose: Write-stream FIFO for register writes
// Assumes: Single clock, synchronous reset
// Notes: Full and empty exact; pointer has an extra wrap bit
`timescale 1ns/10ps
module rspi_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 32
) (
  input wire logic clk_in,
  input wire logic rst_in,
  rspi_fifo_if.snk wr,
  input wire logic rd_ready_in,
  output logic rd_valid_out,
  output logic [WIDTH-1:0] rd_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wp_q;
  logic [AW:0] rp_q;
  wire empty = (wp_q == rp_q);
  wire full = (wp_q[AW-1:0] == rp_q[AW-1:0]) && (wp_q[AW] != rp_q[AW]);
  wire push = wr.valid && !full;
  wire pop = rd_ready_in && !empty;
  assign wr.ready = !full;
  assign rd_valid_out = !empty;
  assign rd_data_out = mem_q[rp_q[AW-1:0]];

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_q[wp_q[AW-1:0]] <= wr.data;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
    end
  end
endmodule

// *** rspi_master_model.sv ***
// Purpose: Serial master model for the radio register port
// Assumes: Mode 0 framing, 125 ns serial clock
// Notes: Clock stands still outside frames
`timescale 1ns/10ps
module rspi_master_model (
  input wire logic clk_in,
  output logic sck_out,
  output logic ss_n_out,
  output logic d_out,
  output logic oe_out,
  input wire logic d_in
);
  initial begin
    sck_out = 1'b0;
    ss_n_out = 1'b1;
    d_out = 1'b0;
    oe_out = 1'b0;
  end
  // Link edges sit a quarter clock off the bench clock, so none race it
  task automatic sel(input logic on);
    repeat (20) @(negedge clk_in);
    #1.25 ss_n_out = !on;
    oe_out = 1'b0;
    repeat (20) @(negedge clk_in);
    #1.25;
  endtask
  // Drive released between bytes so the radio may own the shared pin
  task automatic xfer(input logic [7:0] tx, input logic drv, input int nb,
                      output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nb; i--) begin
      d_out = tx[i];
      oe_out = drv;
      #62.5 sck_out = 1'b1;
      rx[i] = d_in;
      #62.5 sck_out = 1'b0;
    end
    oe_out = 1'b0;
  endtask
endmodule

// *** radio_spi_register_port_test.sv ***
// Purpose: Self-checking bench for the radio register port
// Assumes: Master model drives the serial link
// Notes: Write stream collected at the FIFO output
`timescale 1ns/10ps
module radio_spi_register_port_test;
  import rspi_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic three_wire = 1'b0, irq_on_mosi = 1'b0, irq_v = 1'b0, hold = 1'b0;
  logic mg_en = 1'b0, mg_v = 1'b0, ig_en = 1'b0, ig_v = 1'b0, wr_ready = 1'b0;
  logic sck, ss_n, m_d, m_oe, pin, rd_pin, mosi_o, mosi_oe, miso_o, miso_oe;
  logic irq_o, irq_oe, wr_valid, busy, rd_strobe;
  rspi_addr_t rd_addr, fmask = 6'h00;
  rspi_byte_t rd_data;
  int n_strobe = 0;
  logic [13:0] wr_data;
  logic [13:0] got_q[$];
  int err_count = 0, total_checks = 0;
  // Undriven wire shows the inverse of the last master bit
  assign pin = mosi_oe ? mosi_o : (m_oe ? m_d : !m_d);
  assign rd_pin = three_wire ? pin : miso_o;
  rspi_master_model m (.clk_in(clk_in), .sck_out(sck), .ss_n_out(ss_n), .d_out(m_d),
    .oe_out(m_oe), .d_in(rd_pin));
  rspi_port dut (.clk_in(clk_in), .rst_in(rst_in), .sck_in(sck), .ss_n_in(ss_n),
    .mosi_in(pin), .mosi_out(mosi_o), .mosi_oe_out(mosi_oe), .miso_out(miso_o),
    .miso_oe_out(miso_oe), .three_wire_in(three_wire), .irq_on_mosi_in(irq_on_mosi),
    .irq_in(irq_v), .irq_out(irq_o), .irq_oe_out(irq_oe), .miso_gpio_en_in(mg_en),
    .miso_gpio_out_in(mg_v), .irq_gpio_en_in(ig_en), .irq_gpio_out_in(ig_v),
    .file_mask_in(fmask), .rd_addr_out(rd_addr), .rd_data_in(rd_data),
    .rd_strobe_out(rd_strobe), .wr_valid_out(wr_valid), .wr_data_out(wr_data),
    .wr_ready_in(wr_ready), .busy_out(busy));
  initial forever #2.5 clk_in = ~clk_in;
  always @(posedge clk_in) if (wr_valid && wr_ready) got_q.push_back(wr_data);
  always @(negedge clk_in) wr_ready <= !hold && ($urandom % 4 != 0);
  function automatic rspi_byte_t exp_rd(rspi_addr_t a);
    return {2'h0, a} ^ 8'h5a;
  endfunction
  // Without increment a register file steps within the masked low bits
  function automatic rspi_addr_t exp_addr(input logic inc, input rspi_addr_t a, input int i);
    return inc ? a + rspi_addr_t'(i) : (a & ~fmask) | (rspi_addr_t'(i) & fmask);
  endfunction
  assign rd_data = exp_rd(rd_addr);
  always @(negedge clk_in) if (rd_strobe) n_strobe++;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Master and radio must never drive the shared pin at once
  always @(negedge clk_in) if (m_oe) chk(mosi_oe, 1'b0);
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic wr_burst(input logic inc, input rspi_addr_t a, input int n, input int keep);
    logic [13:0] exp_q[$];
    rspi_byte_t d, rx;
    int t;
    n_strobe = 0;
    m.sel(1'b1);
    m.xfer({1'b1, inc, a}, 1'b1, 8, rx);
    chk(mosi_oe, 1'b0);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      m.xfer(d, 1'b1, 8, rx);
      if (i < keep) exp_q.push_back({exp_addr(inc, a, i), d});
    end
    m.sel(1'b0);
    chk(16'(n_strobe), 16'h0000);
    @(negedge clk_in) hold = 1'b0;
    for (t = 0; t < 4000 && got_q.size() < exp_q.size(); t++) @(posedge clk_in);
    if (t == 4000) begin
      err_count++;
      stop_test();
    end
    chk(16'(got_q.size()), 16'(exp_q.size()));
    foreach (exp_q[i]) chk(got_q[i], exp_q[i]);
    got_q = {};
    $display("Test done: write burst of %0d", n);
  endtask
  task automatic rd_burst(input logic tw, input logic inc, input rspi_addr_t a);
    rspi_byte_t rx;
    @(negedge clk_in) three_wire = tw;
    n_strobe = 0;
    m.sel(1'b1);
    chk(busy, 1'b1);
    m.xfer({1'b0, inc, a}, 1'b1, 8, rx);
    for (int i = 0; i < 3; i++) begin
      m.xfer(8'h00, !tw, 8, rx);
      chk(rx, exp_rd(exp_addr(inc, a, i)));
    end
    m.sel(1'b0);
    chk(16'(n_strobe), 16'h0004);
    $display("Test done: read burst");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rspi_byte_t rx;
    void'($urandom(32'ha651));
    repeat (12) @(negedge clk_in);
    rst_in = 1'b0;
    repeat (4) @(negedge clk_in);
    chk(wr_valid, 1'b0);
    for (int k = 0; k < 8; k++) begin
      @(negedge clk_in) fmask = 6'($urandom % 8);
      wr_burst(k[0], 6'($urandom), 1 + k, 1 + k);
      rd_burst(k[1], k[2], 6'($urandom));
    end
    // Abort in mid byte must leave nothing queued
    m.sel(1'b1);
    m.xfer(8'hc3, 1'b1, 8, rx);
    m.xfer(8'h99, 1'b1, 5, rx);
    m.sel(1'b0);
    wr_burst(1'b1, 6'h3e, 2, 2);
    // Queue cannot stall the master, so overflow bytes are lost
    @(negedge clk_in) hold = 1'b1;
    wr_burst(1'b1, 6'h00, 34, 32);
    for (int v = 0; v < 2; v++) begin
      @(negedge clk_in);
      irq_on_mosi = 1'b1;
      irq_v = v[0];
      repeat (6) @(negedge clk_in);
      chk({mosi_oe, mosi_o, irq_oe}, {1'b1, v[0], 1'b0});
      mg_en = 1'b1;
      ig_en = 1'b1;
      mg_v = 1'($urandom);
      ig_v = !mg_v;
      repeat (6) @(negedge clk_in);
      chk({miso_oe, miso_o, irq_oe, irq_o}, {1'b1, mg_v, 1'b1, ig_v});
      mg_en = 1'b0;
      ig_en = 1'b0;
    end
    // Register file of four entries at the fixed address
    @(negedge clk_in) fmask = 6'h03;
    wr_burst(1'b0, 6'h15, 3, 3);
    stop_test();
  end
endmodule
